// ===== verilog/iface_check.sv
// Input interface checker steered by the interface check configuration register.
`timescale 1ns/1ps
`include "iface_check_defs.svh"
module iface_check (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Serial configuration interface, one bit per clock
  input wire logic sif_enable_n_in,
  input wire logic sif_data_in,
  output logic sif_data_out,
  output logic sif_data_oe_n_out,
  // Parallel input bus
  input wire logic [15:0] data_a_in,
  input wire logic [15:0] data_b_in,
  input wire logic [15:0] data_c_in,
  input wire logic [15:0] data_d_in,
  input wire logic sync_input_pair_in,
  input wire logic parity_input_pair_in,
  input wire logic sample_strobe_pair_in,
  // FIFO pointer events, output enables and alarm clear
  input wire logic ptr_two_apart_in,
  input wire logic ptr_one_apart_in,
  input wire logic ptr_collision_in,
  input wire logic transmit_enable_pin_in,
  input wire logic sif_txenable_in,
  input wire logic alarm_clear_in,
  // Results
  output logic [15:0] data_a_out,
  output logic [15:0] data_b_out,
  output logic [15:0] data_c_out,
  output logic [15:0] data_d_out,
  output logic sample_valid_out,
  output logic sync_out,
  output logic analog_enable_out,
  output logic [2:0] ptr_alarm_out,
  output logic parity_alarm_out,
  output logic pattern_alarm_out
);
  cfg_if cfg ();
  logic [15:0] cfg_value;

  // ==========================================================
  // Serial access: R/W bit, 7 address bits, 16 data bits, MSB first.
  iface_check_pkg::sif_state_t st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] sh_reg, sh_next;
  logic rd_reg, rd_next;
  logic wr_pulse;
  logic out_reg, out_next;
  logic oe_n_reg, oe_n_next;

  // A read of the configuration address loads the register into the shifter.
  // Its bits then leave on the data line one clock behind each data slot.
  // Raising the frame select at any time drops the frame without a write.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    out_next = out_reg;
    oe_n_next = 1'b1;
    wr_pulse = 1'b0;
    if (sif_enable_n_in) begin
      st_next = iface_check_pkg::SIF_IDLE;
      cnt_next = 5'h0_0;
    end else begin
      case (st_reg)
        iface_check_pkg::SIF_IDLE: begin
          rd_next = sif_data_in;
          cnt_next = 5'h0_0;
          st_next = iface_check_pkg::SIF_ADDR;
        end
        iface_check_pkg::SIF_ADDR: begin
          sh_next = {sh_reg[22:0], sif_data_in};
          cnt_next = cnt_reg + 5'h0_1;
          if (cnt_reg == 5'h0_6) begin
            cnt_next = 5'h0_0;
            st_next = iface_check_pkg::SIF_DATA;
            if (rd_reg && {sh_reg[5:0], sif_data_in} == `CFG_ADDR) begin
              sh_next = {sh_reg[5:0], sif_data_in, cfg_value, 1'b0};
            end
          end
        end
        iface_check_pkg::SIF_DATA: begin
          sh_next = {sh_reg[22:0], sif_data_in};
          cnt_next = cnt_reg + 5'h0_1;
          if (rd_reg) begin
            out_next = sh_reg[16];
            oe_n_next = 1'b0;
          end
          if (cnt_reg == 5'h0_F) begin
            wr_pulse = ~rd_reg;
            st_next = iface_check_pkg::SIF_IDLE;
          end
        end
        default: st_next = iface_check_pkg::SIF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg <= iface_check_pkg::SIF_IDLE;
      cnt_reg <= 5'h0_0;
      sh_reg <= 24'h00_0000;
      rd_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign sif_data_out = out_reg;
  assign sif_data_oe_n_out = oe_n_reg;

  cfg_bank u_bank (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .wr_in(wr_pulse),
    .addr_in(sh_reg[21:15]),
    .wdata_in({sh_reg[14:0], sif_data_in}),
    .value_out(cfg_value),
    .cfg(cfg)
  );

  // ==========================================================
  // Checking datapath.
  function automatic logic parity_of(input logic [31:0] w, input logic odd);
    parity_of = (^w) ^ odd;
  endfunction

  logic strobe, sync_r, par;
  logic good;
  logic par_err, pat_err;
  logic [15:0] a_next, b_next, c_next, d_next;
  logic [15:0] a_reg, b_reg, c_reg, d_reg;
  logic [15:0] pat_reg, pat_next;
  logic val_reg, sync_reg, an_reg;
  logic par_al_reg, par_al_next, pat_al_reg, pat_al_next;
  logic [2:0] ptr_reg, ptr_next;
  logic [6:0] good_reg, good_next;
  logic auto_clr;

  always_comb begin
    strobe = cfg.rev_iface ? sync_input_pair_in : sample_strobe_pair_in;
    sync_r = cfg.rev_iface ? parity_input_pair_in : sync_input_pair_in;
    par = cfg.rev_iface ? sample_strobe_pair_in : parity_input_pair_in;
    a_next = data_a_in ^ {16{cfg.chan_invert[3]}};
    b_next = data_b_in ^ {16{cfg.chan_invert[2]}};
    c_next = data_c_in ^ {16{cfg.chan_invert[1]}};
    d_next = data_d_in ^ {16{cfg.chan_invert[0]}};
    par_err = 1'b0;
    if (cfg.parity_en && strobe) begin
      if (cfg.dual_parity) begin
        par_err = (parity_of({data_a_in, data_b_in}, cfg.odd_parity) != par) ||
                  (parity_of({data_c_in, data_d_in}, cfg.odd_parity) != par);
      end else begin
        par_err = parity_of({data_a_in ^ data_c_in, data_b_in ^ data_d_in},
                            cfg.odd_parity) != par;
      end
    end
    pat_err = cfg.pattern_test && strobe &&
              (data_a_in != pat_reg || data_b_in != ~pat_reg ||
               data_c_in != pat_reg || data_d_in != ~pat_reg);
    pat_next = pat_reg;
    if (cfg.pattern_test && strobe) begin
      pat_next = {pat_reg[14:0], pat_reg[15]};
    end
    good = strobe && !par_err && !pat_err;
    good_next = good_reg;
    if (strobe) begin
      good_next = good ? ((good_reg == `GOOD_SAMPLES) ? 7'h0_0 : good_reg + 7'h0_1) : 7'h0_0;
    end
    auto_clr = cfg.auto_clear && good && good_reg == `GOOD_SAMPLES - 7'h0_1;
    par_al_next = par_al_reg;
    pat_al_next = pat_al_reg;
    ptr_next = ptr_reg;
    // Clears are applied first so that an event in the same cycle still sets.
    // Losing such an event would hide a real interface fault from software.
    if (alarm_clear_in || auto_clr) begin
      par_al_next = 1'b0;
      pat_al_next = 1'b0;
      ptr_next = 3'h0;
    end
    if (par_err) par_al_next = 1'b1;
    if (pat_err) pat_al_next = 1'b1;
    if (ptr_two_apart_in && cfg.ptr_alarm_en[2]) ptr_next[2] = 1'b1;
    if (ptr_one_apart_in && cfg.ptr_alarm_en[1]) ptr_next[1] = 1'b1;
    if (ptr_collision_in && cfg.ptr_alarm_en[0]) ptr_next[0] = 1'b1;
  end

  // ==========================================================
  // Datapath and alarm registers.
  // Sample data only load on a strobe, so they hold between words.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      a_reg <= 16'h0000;
      b_reg <= 16'h0000;
      c_reg <= 16'h0000;
      d_reg <= 16'h0000;
      val_reg <= 1'b0;
      sync_reg <= 1'b0;
      an_reg <= 1'b0;
      pat_reg <= `PATTERN_SEED;
      good_reg <= 7'h0_0;
      par_al_reg <= 1'b0;
      pat_al_reg <= 1'b0;
      ptr_reg <= 3'h0;
    end else begin
      if (strobe) begin
        a_reg <= a_next;
        b_reg <= b_next;
        c_reg <= c_next;
        d_reg <= d_next;
      end
      val_reg <= strobe;
      sync_reg <= sync_r;
      an_reg <= !cfg.pattern_test && transmit_enable_pin_in && sif_txenable_in;
      pat_reg <= pat_next;
      good_reg <= good_next;
      par_al_reg <= par_al_next;
      pat_al_reg <= pat_al_next;
      ptr_reg <= ptr_next;
    end
  end

  assign data_a_out = a_reg;
  assign data_b_out = b_reg;
  assign data_c_out = c_reg;
  assign data_d_out = d_reg;
  assign sample_valid_out = val_reg;
  assign sync_out = sync_reg;
  assign analog_enable_out = an_reg;
  assign ptr_alarm_out = ptr_reg;
  assign parity_alarm_out = par_al_reg;
  assign pattern_alarm_out = pat_al_reg;
endmodule

// ===== shared/iface_check_defs.svh
// Offsets, field positions, reset values and counts of the interface check block.
`ifndef IFACE_CHECK_DEFS_SVH
`define IFACE_CHECK_DEFS_SVH
`define CFG_ADDR 7'h01
`define CFG_RESET 16'h040E
`define CFG_WMASK 16'h9FFE
`define BIT_PATTERN_TEST 15
`define BIT_AUTO_CLEAR 12
`define BIT_ODD_PARITY 11
`define BIT_PARITY_EN 10
`define BIT_DUAL_PARITY 9
`define BIT_REV_IFACE 8
`define BIT_CHAN_A_INV 7
`define BIT_CHAN_D_INV 4
`define BIT_PTR_TWO 3
`define BIT_PTR_ONE 2
`define BIT_PTR_COLL 1
`define GOOD_SAMPLES 7'h40
`define PATTERN_SEED 16'hA5C3
`endif

// ===== shared/iface_check_pkg.sv
// Types shared by the interface check block.
package iface_check_pkg;
  typedef enum logic [2:0] {
    SIF_IDLE = 3'b001,
    SIF_ADDR = 3'b010,
    SIF_DATA = 3'b100
  } sif_state_t;
  typedef logic [15:0] word_t;
endpackage

// ===== shared/cfg_if.sv
// Carries configuration fields from the register bank to the check logic.
`timescale 1ns/1ps
interface cfg_if;
  logic pattern_test;
  logic auto_clear;
  logic odd_parity;
  logic parity_en;
  logic dual_parity;
  logic rev_iface;
  logic [3:0] chan_invert;
  logic [2:0] ptr_alarm_en;
  modport bank (output pattern_test, auto_clear, odd_parity, parity_en, dual_parity,
                rev_iface, chan_invert, ptr_alarm_en);
  modport user (input pattern_test, auto_clear, odd_parity, parity_en, dual_parity,
                rev_iface, chan_invert, ptr_alarm_en);
endinterface

// ===== verilog/cfg_bank.sv
// Serial-written configuration register at address 0x01 with its field decode.
`timescale 1ns/1ps
`include "iface_check_defs.svh"
module cfg_bank (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Decoded serial access
  input wire logic wr_in,
  input wire logic [6:0] addr_in,
  input wire logic [15:0] wdata_in,
  // Register contents and fields
  output logic [15:0] value_out,
  cfg_if.bank cfg
);
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_in && addr_in == `CFG_ADDR) begin
      cfg_next = wdata_in & `CFG_WMASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cfg_reg <= `CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign value_out = cfg_reg;
  assign cfg.pattern_test = cfg_reg[`BIT_PATTERN_TEST];
  assign cfg.auto_clear = cfg_reg[`BIT_AUTO_CLEAR];
  assign cfg.odd_parity = cfg_reg[`BIT_ODD_PARITY];
  assign cfg.parity_en = cfg_reg[`BIT_PARITY_EN];
  assign cfg.dual_parity = cfg_reg[`BIT_DUAL_PARITY];
  assign cfg.rev_iface = cfg_reg[`BIT_REV_IFACE];
  assign cfg.chan_invert = cfg_reg[`BIT_CHAN_A_INV:`BIT_CHAN_D_INV];
  assign cfg.ptr_alarm_en = cfg_reg[`BIT_PTR_TWO:`BIT_PTR_COLL];
endmodule

// ===== sim/iface_check_assertions.sv
// Port-level checks for the interface check block.
`timescale 1ns/1ps
module iface_check_assertions (
  // Clock, reset and inputs
  input wire logic clk_in, srst_in, sif_enable_n_in, sample_strobe_pair_in, sync_input_pair_in,
  input wire logic transmit_enable_pin_in, sif_txenable_in, alarm_clear_in,
  input wire logic ptr_two_apart_in, ptr_one_apart_in, ptr_collision_in,
  // Outputs
  input wire logic sif_data_oe_n_out, sample_valid_out, analog_enable_out,
  input wire logic [2:0] ptr_alarm_out,
  input wire logic parity_alarm_out, pattern_alarm_out
);
  // ==========================================
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_rst;
    $past(srst_in) |-> ptr_alarm_out == 3'h0 && !parity_alarm_out && !pattern_alarm_out
      && !analog_enable_out && sif_data_oe_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  property p_ana;
    analog_enable_out |-> $past(transmit_enable_pin_in) && $past(sif_txenable_in);
  endproperty
  a_ana: assert property (p_ana) else $error("analog enable without both enables");
  property p_pat;
    $rose(pattern_alarm_out) |-> !analog_enable_out;
  endproperty
  a_pat: assert property (p_pat) else $error("outputs on during pattern test");
  property p_sv;
    sample_valid_out |-> $past(sample_strobe_pair_in || sync_input_pair_in)
      || $past(sample_strobe_pair_in || sync_input_pair_in, 2);
  endproperty
  a_sv: assert property (p_sv) else $error("sample valid without strobe");
  property p_oe;
    !sif_data_oe_n_out |-> $past(!sif_enable_n_in);
  endproperty
  a_oe: assert property (p_oe) else $error("read data driven outside frame");
  property p_two;
    $rose(ptr_alarm_out[2]) |-> $past(ptr_two_apart_in) || $past(ptr_two_apart_in, 2);
  endproperty
  a_two: assert property (p_two) else $error("two apart alarm without event");
  property p_one;
    $rose(ptr_alarm_out[1]) |-> $past(ptr_one_apart_in) || $past(ptr_one_apart_in, 2);
  endproperty
  a_one: assert property (p_one) else $error("one apart alarm without event");
  property p_coll;
    $rose(ptr_alarm_out[0]) |-> $past(ptr_collision_in) || $past(ptr_collision_in, 2);
  endproperty
  a_coll: assert property (p_coll) else $error("collision alarm without event");
  property p_stick;
    $fell(parity_alarm_out) |-> $past(alarm_clear_in) || $past(alarm_clear_in, 2)
      || sample_valid_out || $past(sample_valid_out);
  endproperty
  a_stick: assert property (p_stick) else $error("parity alarm dropped by itself");
  c_rd: cover property ($fell(sif_data_oe_n_out));
  c_par: cover property ($rose(parity_alarm_out));
  c_auto: cover property ($fell(parity_alarm_out) && !$past(alarm_clear_in));
endmodule
bind iface_check iface_check_assertions chk (.clk_in, .srst_in, .sif_enable_n_in,
  .sample_strobe_pair_in, .sync_input_pair_in, .transmit_enable_pin_in, .sif_txenable_in,
  .alarm_clear_in, .ptr_two_apart_in, .ptr_one_apart_in, .ptr_collision_in,
  .sif_data_oe_n_out, .sample_valid_out, .analog_enable_out, .ptr_alarm_out,
  .parity_alarm_out, .pattern_alarm_out);

// ===== sim/host_model.sv
// Host logic model driving the parallel input bus with parity.
`timescale 1ns/1ps
`include "iface_check_defs.svh"
module host_model (
  // Clock and controls
  input wire logic clk_in,
  input wire logic run_in, slow_in, odd_in, dual_in, rev_in, bad_in,
  input wire logic pat_in, pgood_in,
  // Bus toward the device
  output logic [15:0] a_out, b_out, c_out, d_out,
  output logic sync_out, parity_out, strobe_out
);
  logic [15:0] a, b, c, d, p;
  logic stb, par, par_last, sy;
  initial begin
    {a_out, b_out, c_out, d_out, sync_out, parity_out, strobe_out, par_last} = '0;
    p = `PATTERN_SEED;
  end
  // Between strobes the lines show the inverse so stale data is never trusted.
  always @(posedge clk_in) begin
    stb = run_in && (!slow_in || $urandom_range(1) == 1);
    sy = 1'($urandom_range(1));
    {a, b, c, d} = stb ? {$urandom, $urandom} : ~{a_out, b_out, c_out, d_out};
    if (stb && pgood_in) {a, b, c, d} = {p, ~p, p, ~p};
    if (stb && pat_in) p = {p[14:0], p[15]};
    if (dual_in) d[0] = d[0] ^ (^{a, b, c, d});
    par = (dual_in ? ^{a, b} : ^{a, b, c, d}) ^ odd_in ^ bad_in;
    if (!stb) par = ~par_last;
    par_last = par;
    {a_out, b_out, c_out, d_out} <= {a, b, c, d};
    strobe_out <= rev_in ? par : stb;
    sync_out <= rev_in ? stb : sy;
    parity_out <= rev_in ? sy : par;
  end
endmodule

// ===== sim/dac_input_check_config_test.sv
// Self-checking bench for the interface check configuration block.
`timescale 1ns/1ps
`include "iface_check_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module dac_input_check_config_test;
  logic clk_in, srst_in, en_n, sdi, sdo, oe_n, tx_pin, tx_sif, clr, two, one, coll;
  logic run, slow, bad, valid, sync_o, ana, par_al, pat_al, sync_p, par_p, stb_p;
  logic pgood, sy, rs;
  logic [2:0] ptr;
  logic [15:0] da, db, dc, dd, qa, qb, qc, qd, cfg, rq;
  logic [63:0] q[$];
  int errors = 0;
  int comparisons = 0;
  iface_check uut (.clk_in, .srst_in, .sif_enable_n_in(en_n), .sif_data_in(sdi),
    .sif_data_out(sdo), .sif_data_oe_n_out(oe_n), .data_a_in(da), .data_b_in(db),
    .data_c_in(dc), .data_d_in(dd), .sync_input_pair_in(sync_p), .parity_input_pair_in(par_p),
    .sample_strobe_pair_in(stb_p), .ptr_two_apart_in(two), .ptr_one_apart_in(one),
    .ptr_collision_in(coll), .transmit_enable_pin_in(tx_pin), .sif_txenable_in(tx_sif),
    .alarm_clear_in(clr), .data_a_out(qa), .data_b_out(qb), .data_c_out(qc),
    .data_d_out(qd), .sample_valid_out(valid), .sync_out(sync_o), .analog_enable_out(ana),
    .ptr_alarm_out(ptr), .parity_alarm_out(par_al), .pattern_alarm_out(pat_al));
  host_model host (.clk_in, .run_in(run), .slow_in(slow), .odd_in(cfg[11]), .dual_in(cfg[9]),
    .rev_in(cfg[8]), .bad_in(bad), .pat_in(cfg[15]), .pgood_in(pgood),
    .a_out(da), .b_out(db), .c_out(dc), .d_out(dd),
    .sync_out(sync_p), .parity_out(par_p), .strobe_out(stb_p));
  initial begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ==========================================
  // Scoreboard of strobed words
  always @(posedge clk_in) begin
    if (cfg[8] ? sync_p : stb_p) q.push_back({da, db, dc, dd});
    sy = cfg[8] ? par_p : sync_p;
    rs = srst_in;
    #1;
    if (!rs) `CHK(sync_o, sy)
    if (valid === 1'b1) `CHK({qa, qb, qc, qd}, q.pop_front() ^ {{16{cfg[7]}}, {16{cfg[6]}},
      {16{cfg[5]}}, {16{cfg[4]}}})
  end
  // ==========================================
  // Tasks
  task automatic sif(input logic rd, input logic [6:0] ad, input logic [15:0] wd);
    logic [23:0] f;
    f = {rd, ad, wd};
    for (int i = 23; i >= -2; i--) begin
      @(posedge clk_in);
      en_n <= (i < 0);
      sdi <= f[23];
      f = f << 1;
      #1 if (oe_n === 1'b0) rq = {rq[14:0], sdo};
      if (i == -1 && !rd && ad == `CFG_ADDR) cfg = wd & `CFG_WMASK;
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic go(input int n);
    @(posedge clk_in);
    run <= 1;
    repeat (n) @(posedge clk_in);
    run <= 0;
    wait_n(4);
  endtask
  task automatic clr_alarms;
    @(posedge clk_in);
    clr <= 1;
    @(posedge clk_in);
    clr <= 0;
    wait_n(2);
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    {srst_in, en_n, sdi, tx_pin, tx_sif, clr, two, one, coll} = 9'h180;
    {run, slow, bad, pgood} = 4'h0;
    cfg = `CFG_RESET;
    void'($urandom(32'h6adb));
    repeat (16) @(posedge clk_in);
    srst_in <= 0;
    sif(1, `CFG_ADDR, 16'h0000);
    `CHK(rq, 16'h040E)
    sif(0, `CFG_ADDR, 16'hFFFF);
    sif(1, `CFG_ADDR, 16'h0000);
    `CHK(rq, 16'h9FFE)
    sif(0, 7'h05, 16'h0000);
    sif(1, `CFG_ADDR, 16'h0000);
    `CHK(rq, cfg)
    for (int k = 0; k < 8; k++) begin
      sif(0, `CFG_ADDR, 16'(k) << 1);
      clr_alarms();
      @(posedge clk_in);
      {two, one, coll} <= 3'h7;
      @(posedge clk_in);
      {two, one, coll} <= 3'h0;
      wait_n(3);
      `CHK(ptr, 3'(k))
    end
    for (int m = 0; m < 16; m++) begin
      sif(0, `CFG_ADDR, {4'h0, m[0], !m[3], m[1], 9'h000} | (16'($urandom) & 16'h01F0));
      clr_alarms();
      bad = m[2];
      slow = $urandom_range(1);
      go(40);
      `CHK(par_al, m[2] & !m[3])
      `CHK(q.size(), 0)
      bad = 0;
    end
    sif(0, `CFG_ADDR, 16'h1400);
    slow = 0;
    bad = 1;
    go(3);
    bad = 0;
    `CHK(par_al, 1'b1)
    go(62);
    `CHK(par_al, 1'b1)
    go(4);
    `CHK(par_al, 1'b0)
    sif(0, `CFG_ADDR, 16'h0400);
    bad = 1;
    go(2);
    bad = 0;
    go(80);
    `CHK(par_al, 1'b1)
    clr_alarms();
    `CHK(par_al, 1'b0)
    for (int m = 0; m < 8; m++) begin
      sif(0, `CFG_ADDR, {m[2], 15'h0000});
      @(posedge clk_in);
      tx_pin <= m[0];
      tx_sif <= m[1];
      clr_alarms();
      go(8);
      `CHK(ana, m[0] & m[1] & !m[2])
      `CHK(pat_al, m[2])
    end
    sif(0, `CFG_ADDR, 16'h8000);
    clr_alarms();
    pgood = 1;
    go(20);
    pgood = 0;
    `CHK(pat_al, 1'b0)
    `CHK(ana, 1'b0)
    stop_test();
  end
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule
